// File: dv/core_register_file_model.sv
// behavioural register file on the write-back side of the pack and extend unit
// assumes write-back arrives as a one-cycle enable with index and data
`timescale 1ns/1ps
module core_register_file_model (
	// clock
	input wire logic clk_sys,
	// operand preload from the bench, stored at the clock edge
	input wire logic preload,
	input wire logic [31:0] preload_first,
	input wire logic [31:0] preload_second,
	// read ports
	input wire logic [3:0] first_sel,
	input wire logic [3:0] second_sel,
	output logic [31:0] first_value,
	output logic [31:0] second_value,
	// write-back port
	input wire logic write_enable,
	input wire logic [3:0] write_index,
	input wire logic [31:0] write_data
);
	logic [31:0] regs [16];
	int bad_writes = 0;

	// operands are read without delay
	assign first_value = regs[first_sel];
	assign second_value = regs[second_sel];

	// store preload and write-back, count writes the program must never cause
	always @(posedge clk_sys) begin
		if (preload) begin
			regs[first_sel] <= preload_first;
			regs[second_sel] <= preload_second;
		end
		if (write_enable) begin
			regs[write_index] <= write_data;
			if (write_index == pack_extend_pkg::stack_pointer_index ||
				write_index == pack_extend_pkg::program_counter_index) begin
				bad_writes <= bad_writes + 1;
			end
		end
	end
endmodule

// File: dv/halfword_pack_and_extend_unit_bench.sv
// self-checking bench for the halfword pack and extend unit
// assumes a one-cycle registered result and the register file model as operand source
`timescale 1ns/1ps
module halfword_pack_and_extend_unit_bench;
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	logic issue = 1'b0;
	pack_extend_pkg::op_e op = pack_extend_pkg::op_none;
	logic condition_pass = 1'b0;
	logic [4:0] shift_amount = 5'h00;
	logic [1:0] rotate_sel = 2'h0;
	logic [3:0] dest_index = 4'h0;
	logic [31:0] first_operand, second_operand, write_data, last_data;
	logic write_enable, flags_write;
	logic [3:0] write_index;
	logic [3:0] last_index;
	logic preload = 1'b0;
	logic [31:0] load_first = 32'h0000_0000;
	logic [31:0] load_second = 32'h0000_0000;
	int error_cnt = 0;
	int total_checks = 0;

	// 40 MHz clock
	always #12.5 clk_sys = ~clk_sys;

	halfword_pack_and_extend_unit i_halfword_pack_and_extend_unit (.clk_sys(clk_sys), .reset(reset),
		.issue(issue), .op(op), .condition_pass(condition_pass), .shift_amount(shift_amount),
		.rotate_sel(rotate_sel), .dest_index(dest_index), .first_operand(first_operand),
		.second_operand(second_operand), .write_enable(write_enable), .write_index(write_index),
		.write_data(write_data), .flags_write(flags_write));
	core_register_file_model i_core_register_file_model (.clk_sys(clk_sys), .preload(preload),
		.preload_first(load_first), .preload_second(load_second), .first_sel(4'h1),
		.second_sel(4'h2), .first_value(first_operand), .second_value(second_operand),
		.write_enable(write_enable), .write_index(write_index), .write_data(write_data));

	// compare one value and count it
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// expected result worked out independently of the design
	function automatic logic [31:0] expect_f(pack_extend_pkg::op_e o, logic [31:0] a, logic [31:0] b,
		logic [4:0] s, logic [1:0] q);
		logic [63:0] w;
		logic [31:0] r, e;
		w = {b, b} >> (q * 8);
		r = w[31:0];
		e = 32'h0000_0000;
		case (o)
			pack_extend_pkg::pack_bottom_top: begin
				e = b << s;
				return {e[31:16], a[15:0]};
			end
			pack_extend_pkg::pack_top_bottom: begin
				w = {{32{b[31]}}, b} >> ((s == 5'h00) ? 32 : s);
				return {a[31:16], w[15:0]};
			end
			pack_extend_pkg::sign_extend_byte, pack_extend_pkg::sign_extend_byte_add: e = {{24{r[7]}}, r[7:0]};
			pack_extend_pkg::zero_extend_byte, pack_extend_pkg::zero_extend_byte_add: e = {24'h000000, r[7:0]};
			pack_extend_pkg::sign_extend_half, pack_extend_pkg::sign_extend_half_add: e = {{16{r[15]}}, r[15:0]};
			pack_extend_pkg::zero_extend_half, pack_extend_pkg::zero_extend_half_add: e = {16'h0000, r[15:0]};
			pack_extend_pkg::dual_sign_extend_byte, pack_extend_pkg::dual_sign_extend_byte_add:
				e = {{8{r[23]}}, r[23:16], {8{r[7]}}, r[7:0]};
			default: e = {8'h00, r[23:16], 8'h00, r[7:0]};
		endcase
		if (o == pack_extend_pkg::dual_sign_extend_byte_add || o == pack_extend_pkg::dual_zero_extend_byte_add)
			return {a[31:16] + e[31:16], a[15:0] + e[15:0]};
		if (o >= pack_extend_pkg::sign_extend_byte_add)
			return a + e;
		return e;
	endfunction

	// issue one instruction and judge write-back, flags and register file
	task automatic exec(input pack_extend_pkg::op_e o, input logic [31:0] a, input logic [31:0] b,
		input logic [4:0] s, input logic [1:0] q, input logic c, input logic [3:0] d);
		logic [31:0] exp;
		logic acc;
		acc = c && (o != pack_extend_pkg::op_none);
		exp = acc ? expect_f(o, a, b, s, q) : last_data;
		@(posedge clk_sys);
		preload <= 1'b1;
		load_first <= a;
		load_second <= b;
		@(posedge clk_sys);
		preload <= 1'b0;
		issue <= 1'b1;
		op <= o;
		shift_amount <= s;
		rotate_sel <= q;
		condition_pass <= c;
		dest_index <= d;
		@(posedge clk_sys);
		issue <= 1'b0;
		#1;
		check({31'h0, write_enable}, {31'h0, acc});
		check({28'h0, write_index}, {28'h0, acc ? d : last_index});
		check(write_data, exp);
		check({31'h0, flags_write}, 32'h0000_0000);
		@(posedge clk_sys);
		#1;
		if (acc) check(i_core_register_file_model.regs[d], exp);
		last_data = exp;
		if (acc) last_index = d;
	endtask

	// pack with shift boundaries, negative and positive second operand
	task automatic pack_scenario();
		exec(pack_extend_pkg::pack_bottom_top, 32'h1234_5678, 32'h9ABC_DEF0, 5'h00, 2'h0, 1'b1, 4'h3);
		exec(pack_extend_pkg::pack_bottom_top, 32'h1234_5678, 32'h9ABC_DEF1, 5'h1F, 2'h0, 1'b1, 4'h4);
		exec(pack_extend_pkg::pack_top_bottom, 32'h1234_5678, 32'h9ABC_DEF0, 5'h00, 2'h0, 1'b1, 4'h5);
		exec(pack_extend_pkg::pack_top_bottom, 32'h1234_5678, 32'h8001_2340, 5'h01, 2'h0, 1'b1, 4'h6);
		exec(pack_extend_pkg::pack_top_bottom, 32'hFFFF_0000, 32'h7FFF_8000, 5'h10, 2'h0, 1'b1, 4'h7);
	endtask

	// every extend and extend-add op at every rotation
	task automatic extend_scenario();
		for (int k = 3; k <= 14; k++) begin
			for (int q = 0; q < 4; q++) begin
				exec(pack_extend_pkg::op_e'(k), 32'h7FF0_80F0, 32'h80F1_7F82, 5'h00, q[1:0], 1'b1, 4'h8);
			end
		end
	endtask

	// false condition and no-op leave outputs unchanged
	task automatic refuse_scenario();
		exec(pack_extend_pkg::zero_extend_half, 32'h0000_0000, 32'hAAAA_5555, 5'h00, 2'h1, 1'b0, 4'h9);
		exec(pack_extend_pkg::op_none, 32'h0000_0000, 32'h1234_5678, 5'h00, 2'h0, 1'b1, 4'hB);
		exec(pack_extend_pkg::sign_extend_byte, 32'h0000_0000, 32'h0000_0080, 5'h00, 2'h0, 1'b1, 4'hA);
	endtask

	// report counts and verdict, then stop
	task automatic conclude();
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// watchdog against a hang
	initial begin
		#1ms;
		error_cnt++;
		conclude();
	end

	// main sequence
	initial begin
		last_data = 32'h0000_0000;
		last_index = 4'h0;
		repeat (3) @(posedge clk_sys);
		reset <= 1'b0;
		#1;
		check({write_enable, flags_write, write_index}, 32'h0000_0000);
		check(write_data, 32'h0000_0000);
		pack_scenario();
		extend_scenario();
		refuse_scenario();
		check(i_core_register_file_model.bad_writes, 32'h0000_0000);
		conclude();
	end
endmodule

// File: hw/halfword_pack.sv
// pack datapath: combines halves of two operands with an optional shift
// assumes operands stable for the cycle; purely combinational
`timescale 1ns/1ps
module halfword_pack (
	// operation select
	input wire logic top_bottom,
	input wire logic [pack_extend_pkg::shift_width-1:0] shift_amount,
	// operands
	input wire logic [pack_extend_pkg::word_width-1:0] first_operand,
	input wire logic [pack_extend_pkg::word_width-1:0] second_operand,
	// result
	output logic [pack_extend_pkg::word_width-1:0] packed_word
);
	logic [pack_extend_pkg::word_width-1:0] shifted_left;
	logic signed [pack_extend_pkg::word_width-1:0] shifted_right;
	logic [5:0] asr_amount;

	// shift then merge halves
	always_comb begin
		shifted_left = second_operand << shift_amount;
		asr_amount = (shift_amount == '0) ? pack_extend_pkg::asr_full_shift : {1'b0, shift_amount};
		shifted_right = $signed(second_operand) >>> asr_amount;
		if (top_bottom) begin
			packed_word = {first_operand[31:16], shifted_right[15:0]};
		end else begin
			packed_word = {shifted_left[31:16], first_operand[15:0]};
		end
	end
endmodule

// File: hw/halfword_pack_and_extend_unit.sv
// halfword pack and extend unit: one-cycle datapath with registered result
// assumes the decoder gives op, immediates and the evaluated condition, and the register file gives the operands
// Behaviour
// - bottom-top pack copies first operand bits 15:0 to result 15:0
// - bottom-top pack shifts second operand left 0..31, upper half to 31:16
// - top-bottom pack copies first operand bits 31:16 to result 31:16
// - top-bottom pack shifts second right arithmetically 1..32, field 0 means 32
// - pack leaves condition flags untouched
// - extend rotates source right by 0, 8, 16 or 24 first
// - no rotation given means rotate by zero
// - signed byte extend replicates bit 7 into 31:8
// - unsigned byte extend zero fills 31:8
// - signed halfword extend replicates bit 15 into 31:16
// - unsigned halfword extend zero fills 31:16
// - dual signed byte extend widens bytes 0 and 2 to signed halfwords
// - dual unsigned byte extend widens bytes 0 and 2 to unsigned halfwords
// - extend operations leave condition flags untouched
// - extend-add variants add to word or each halfword of first operand
`timescale 1ns/1ps
module halfword_pack_and_extend_unit (
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// instruction from the decoder
	input wire logic issue,
	input wire pack_extend_pkg::op_e op,
	input wire logic condition_pass,
	input wire logic [pack_extend_pkg::shift_width-1:0] shift_amount,
	input wire logic [pack_extend_pkg::rot_width-1:0] rotate_sel,
	input wire logic [pack_extend_pkg::reg_index_width-1:0] dest_index,
	// operands from the register file
	input wire logic [pack_extend_pkg::word_width-1:0] first_operand,
	input wire logic [pack_extend_pkg::word_width-1:0] second_operand,
	// write back to the register file
	output logic write_enable,
	output logic [pack_extend_pkg::reg_index_width-1:0] write_index,
	output logic [pack_extend_pkg::word_width-1:0] write_data,
	// condition flag write: always idle for this unit
	output logic flags_write
);
	logic is_pack;
	logic sign_fill;
	logic half_size;
	logic dual_byte;
	logic add_variant;
	logic [pack_extend_pkg::word_width-1:0] packed_word;
	logic [pack_extend_pkg::word_width-1:0] extended;
	logic [pack_extend_pkg::word_width-1:0] result;
	logic next_write_enable;
	logic [pack_extend_pkg::reg_index_width-1:0] next_write_index;
	logic [pack_extend_pkg::word_width-1:0] next_write_data;

	// the fixed bit slices below serve only these package widths
	if (pack_extend_pkg::word_width != 32 || pack_extend_pkg::half_width != 16 ||
		pack_extend_pkg::byte_width != 8 || pack_extend_pkg::rot_width != 2) begin : g_width_check
		$error("unsupported pack and extend datapath width");
	end

	// halfword add without carry between halves
	function automatic logic [31:0] dual_half_add(input logic [31:0] a, input logic [31:0] b);
		logic [15:0] hi;
		logic [15:0] lo;
		hi = a[31:16] + b[31:16];
		lo = a[15:0] + b[15:0];
		return {hi, lo};
	endfunction

	// decode the operation into datapath controls
	always_comb begin
		is_pack = 1'b0;
		sign_fill = 1'b0;
		half_size = 1'b0;
		dual_byte = 1'b0;
		add_variant = 1'b0;
		case (op)
			pack_extend_pkg::pack_bottom_top: is_pack = 1'b1;
			pack_extend_pkg::pack_top_bottom: is_pack = 1'b1;
			pack_extend_pkg::sign_extend_byte: sign_fill = 1'b1;
			pack_extend_pkg::sign_extend_half: begin
				sign_fill = 1'b1;
				half_size = 1'b1;
			end
			pack_extend_pkg::dual_sign_extend_byte: begin
				sign_fill = 1'b1;
				dual_byte = 1'b1;
			end
			pack_extend_pkg::zero_extend_half: half_size = 1'b1;
			pack_extend_pkg::dual_zero_extend_byte: dual_byte = 1'b1;
			pack_extend_pkg::sign_extend_byte_add: begin
				sign_fill = 1'b1;
				add_variant = 1'b1;
			end
			pack_extend_pkg::sign_extend_half_add: begin
				sign_fill = 1'b1;
				half_size = 1'b1;
				add_variant = 1'b1;
			end
			pack_extend_pkg::dual_sign_extend_byte_add: begin
				sign_fill = 1'b1;
				dual_byte = 1'b1;
				add_variant = 1'b1;
			end
			pack_extend_pkg::zero_extend_byte_add: add_variant = 1'b1;
			pack_extend_pkg::zero_extend_half_add: begin
				half_size = 1'b1;
				add_variant = 1'b1;
			end
			pack_extend_pkg::dual_zero_extend_byte_add: begin
				dual_byte = 1'b1;
				add_variant = 1'b1;
			end
			default: is_pack = 1'b0;
		endcase
	end

	halfword_pack u_pack (
		.top_bottom(op == pack_extend_pkg::pack_top_bottom),
		.shift_amount(shift_amount),
		.first_operand(first_operand),
		.second_operand(second_operand),
		.packed_word(packed_word)
	);

	rotate_extend u_extend (
		.sign_fill(sign_fill),
		.half_size(half_size),
		.dual_byte(dual_byte),
		.rotate_sel(rotate_sel),
		.source(second_operand),
		.extended(extended)
	);

	// select result and decide write back
	always_comb begin
		if (is_pack) begin
			result = packed_word;
		end else if (add_variant && dual_byte) begin
			result = dual_half_add(first_operand, extended);
		end else if (add_variant) begin
			result = first_operand + extended;
		end else begin
			result = extended;
		end
		next_write_enable = issue && condition_pass && (op != pack_extend_pkg::op_none);
		next_write_index = next_write_enable ? dest_index : write_index;
		next_write_data = next_write_enable ? result : write_data;
	end

	// register the write back
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			write_enable <= 1'b0;
			write_index <= pack_extend_pkg::index_reset;
			write_data <= pack_extend_pkg::result_reset;
			flags_write <= 1'b0;
		end else begin
			write_enable <= next_write_enable;
			write_index <= next_write_index;
			write_data <= next_write_data;
			flags_write <= 1'b0;
		end
	end

	// an instruction the unit takes at this edge
	sequence issue_s;
		issue && condition_pass && (op != pack_extend_pkg::op_none);
	endsequence

	// taken instructions of each pack and plain extend kind, and of two extend-add kinds
	sequence pack_bt_s;
		issue_s and (op == pack_extend_pkg::pack_bottom_top);
	endsequence
	sequence pack_tb_s;
		issue_s and (op == pack_extend_pkg::pack_top_bottom);
	endsequence
	sequence sign_byte_s;
		issue_s and (op == pack_extend_pkg::sign_extend_byte);
	endsequence
	sequence sign_half_s;
		issue_s and (op == pack_extend_pkg::sign_extend_half);
	endsequence
	sequence dual_sign_s;
		issue_s and (op == pack_extend_pkg::dual_sign_extend_byte);
	endsequence
	sequence zero_byte_s;
		issue_s and (op == pack_extend_pkg::zero_extend_byte);
	endsequence
	sequence zero_half_s;
		issue_s and (op == pack_extend_pkg::zero_extend_half);
	endsequence
	sequence dual_zero_s;
		issue_s and (op == pack_extend_pkg::dual_zero_extend_byte);
	endsequence
	sequence zero_byte_add_s;
		issue_s and (op == pack_extend_pkg::zero_extend_byte_add);
	endsequence
	sequence dual_zero_add_s;
		issue_s and (op == pack_extend_pkg::dual_zero_extend_byte_add);
	endsequence

	// pack halves and shifts
	pack_low_half_a: assert property (@(posedge clk_sys) disable iff (reset)
		pack_bt_s |=> write_data[15:0] == $past(first_operand[15:0]))
		else $error("pack bottom half wrong");
	pack_top_shift_a: assert property (@(posedge clk_sys) disable iff (reset)
		pack_bt_s |=> write_data[31:16] == 16'($past(second_operand) << $past(shift_amount) >> 16))
		else $error("pack shifted top half wrong");
	pack_no_shift_a: assert property (@(posedge clk_sys) disable iff (reset)
		(pack_bt_s and (shift_amount == '0)) |=> write_data[31:16] == $past(second_operand[31:16]))
		else $error("unshifted pack top half wrong");
	pack_high_half_a: assert property (@(posedge clk_sys) disable iff (reset)
		pack_tb_s |=> write_data[31:16] == $past(first_operand[31:16]))
		else $error("pack top half wrong");
	pack_asr_full_a: assert property (@(posedge clk_sys) disable iff (reset)
		(pack_tb_s and (shift_amount == '0)) |=> write_data[15:0] == {16{$past(second_operand[31])}})
		else $error("full arithmetic shift wrong");
	pack_asr_one_a: assert property (@(posedge clk_sys) disable iff (reset)
		(pack_tb_s and (shift_amount == 5'h01)) |=> write_data[15:0] == $past(second_operand[16:1]))
		else $error("single arithmetic shift wrong");
	pack_asr_half_a: assert property (@(posedge clk_sys) disable iff (reset)
		(pack_tb_s and (shift_amount == 5'h10)) |=> write_data[15:0] == $past(second_operand[31:16]))
		else $error("halfword arithmetic shift wrong");

	// extend: rotate, extract and fill
	sign_byte_a: assert property (@(posedge clk_sys) disable iff (reset)
		(sign_byte_s and (rotate_sel == 2'h1))
		|=> write_data == {{24{$past(second_operand[15])}}, $past(second_operand[15:8])})
		else $error("signed byte extend wrong");
	sign_byte_plain_a: assert property (@(posedge clk_sys) disable iff (reset)
		(sign_byte_s and (rotate_sel == 2'h0))
		|=> write_data == {{24{$past(second_operand[7])}}, $past(second_operand[7:0])})
		else $error("unrotated signed byte extend wrong");
	zero_byte_a: assert property (@(posedge clk_sys) disable iff (reset)
		(zero_byte_s and (rotate_sel == 2'h2))
		|=> write_data == {24'h000000, $past(second_operand[23:16])})
		else $error("unsigned byte extend wrong");
	sign_half_a: assert property (@(posedge clk_sys) disable iff (reset)
		(sign_half_s and (rotate_sel == 2'h2))
		|=> write_data == {{16{$past(second_operand[31])}}, $past(second_operand[31:16])})
		else $error("signed half extend wrong");
	rotate_wrap_a: assert property (@(posedge clk_sys) disable iff (reset)
		(sign_half_s and (rotate_sel == 2'h3))
		|=> write_data == {{16{$past(second_operand[7])}}, $past(second_operand[7:0]), $past(second_operand[31:24])})
		else $error("wrapped rotation extend wrong");
	zero_half_a: assert property (@(posedge clk_sys) disable iff (reset)
		(zero_half_s and (rotate_sel == 2'h0))
		|=> write_data == {16'h0000, $past(second_operand[15:0])})
		else $error("unsigned half extend wrong");
	half_rot_a: assert property (@(posedge clk_sys) disable iff (reset)
		(zero_half_s and (rotate_sel == 2'h1))
		|=> write_data == {16'h0000, $past(second_operand[23:8])})
		else $error("rotated unsigned half extend wrong");
	dual_sign_a: assert property (@(posedge clk_sys) disable iff (reset)
		(dual_sign_s and (rotate_sel == 2'h0))
		|=> write_data[31:16] == {{8{$past(second_operand[23])}}, $past(second_operand[23:16])})
		else $error("dual signed extend wrong");
	dual_sign_low_a: assert property (@(posedge clk_sys) disable iff (reset)
		(dual_sign_s and (rotate_sel == 2'h0))
		|=> write_data[15:0] == {{8{$past(second_operand[7])}}, $past(second_operand[7:0])})
		else $error("dual signed low half wrong");
	dual_zero_a: assert property (@(posedge clk_sys) disable iff (reset)
		(dual_zero_s and (rotate_sel == 2'h1))
		|=> write_data == {8'h00, $past(second_operand[31:24]), 8'h00, $past(second_operand[15:8])})
		else $error("dual unsigned extend wrong");

	// extend and add
	word_add_a: assert property (@(posedge clk_sys) disable iff (reset)
		(zero_byte_add_s and (rotate_sel == 2'h0))
		|=> write_data == $past(first_operand) + {24'h000000, $past(second_operand[7:0])})
		else $error("byte extend add wrong");
	half_add_a: assert property (@(posedge clk_sys) disable iff (reset)
		(dual_zero_add_s and (rotate_sel == 2'h0))
		|=> write_data[31:16] == 16'($past(first_operand[31:16]) + {8'h00, $past(second_operand[23:16])}))
		else $error("dual extend add top half wrong");
	half_add_low_a: assert property (@(posedge clk_sys) disable iff (reset)
		(dual_zero_add_s and (rotate_sel == 2'h0))
		|=> write_data[15:0] == 16'($past(first_operand[15:0]) + {8'h00, $past(second_operand[7:0])}))
		else $error("dual extend add low half wrong");

	// write back, flags and refusal
	no_flag_write_a: assert property (@(posedge clk_sys) disable iff (reset)
		issue_s |=> !flags_write)
		else $error("flags written");
	write_back_a: assert property (@(posedge clk_sys) disable iff (reset)
		issue_s |=> write_enable && write_index == $past(dest_index))
		else $error("taken instruction not written back");
	cond_false_a: assert property (@(posedge clk_sys) disable iff (reset)
		issue && !condition_pass |=> !write_enable && $stable(write_data))
		else $error("write despite false condition");
	no_op_a: assert property (@(posedge clk_sys) disable iff (reset)
		issue && op == pack_extend_pkg::op_none |=> !write_enable && $stable(write_data) && $stable(write_index))
		else $error("write for an empty operation");
	idle_hold_a: assert property (@(posedge clk_sys) disable iff (reset)
		!issue |=> !write_enable && $stable(write_data) && $stable(write_index))
		else $error("write without an instruction");

	// reset clears every output
	reset_clear_a: assert property (@(posedge clk_sys)
		reset |=> !write_enable && !flags_write && write_index == pack_extend_pkg::index_reset
			&& write_data == pack_extend_pkg::result_reset)
		else $error("outputs not cleared by reset");
endmodule

// File: hw/pack_extend_pkg.sv
// package for the halfword pack and extend unit
// assumes the core decoder supplies an operation code from pack_extend_pkg::op_e
package pack_extend_pkg;
	localparam int unsigned word_width = 32;
	localparam int unsigned half_width = 16;
	localparam int unsigned byte_width = 8;
	localparam int unsigned shift_width = 5;
	localparam int unsigned rot_width = 2;
	localparam int unsigned reg_index_width = 4;
	// register indices the issuing program must avoid as destination or source
	localparam logic [3:0] stack_pointer_index = 4'hD;
	localparam logic [3:0] program_counter_index = 4'hF;
	// an arithmetic right shift field of zero stands for a full word shift
	localparam logic [5:0] asr_full_shift = 6'h20;
	localparam logic [31:0] result_reset = 32'h0000_0000;
	localparam logic [3:0] index_reset = 4'h0;

	typedef enum logic [3:0] {
		op_none,
		pack_bottom_top,
		pack_top_bottom,
		sign_extend_byte,
		sign_extend_half,
		dual_sign_extend_byte,
		zero_extend_byte,
		zero_extend_half,
		dual_zero_extend_byte,
		sign_extend_byte_add,
		sign_extend_half_add,
		dual_sign_extend_byte_add,
		zero_extend_byte_add,
		zero_extend_half_add,
		dual_zero_extend_byte_add
	} op_e;
endpackage

// File: hw/rotate_extend.sv
// extend datapath: rotates the source then sign or zero extends it
// assumes the rotation select is 0 when the instruction names none
`timescale 1ns/1ps
module rotate_extend (
	// operation select
	input wire logic sign_fill,
	input wire logic half_size,
	input wire logic dual_byte,
	input wire logic [pack_extend_pkg::rot_width-1:0] rotate_sel,
	// operand
	input wire logic [pack_extend_pkg::word_width-1:0] source,
	// result
	output logic [pack_extend_pkg::word_width-1:0] extended
);
	logic [pack_extend_pkg::word_width-1:0] rotated;
	logic [4:0] rot_bits;

	// rotate right by a whole number of bytes, then extract and fill
	always_comb begin
		rot_bits = {rotate_sel, 3'b000};
		rotated = (source >> rot_bits) | (source << (6'd32 - {1'b0, rot_bits}));
		if (dual_byte) begin
			extended = {{8{sign_fill & rotated[23]}}, rotated[23:16],
				{8{sign_fill & rotated[7]}}, rotated[7:0]};
		end else if (half_size) begin
			extended = {{16{sign_fill & rotated[15]}}, rotated[15:0]};
		end else begin
			extended = {{24{sign_fill & rotated[7]}}, rotated[7:0]};
		end
	end
endmodule
